/* File: src/ecec_pkg.sv */
`default_nettype none
package ecec_pkg;
   // ****************************************
   // Address map
   // ****************************************
   localparam logic [31:0] ARRAY_BASE  = 32'h0000_0800;
   localparam logic [31:0] ARRAY_MASK  = 32'hFFFF_F800;
   localparam logic [31:0] REGS_MASK   = 32'hFFFF_FFE0;
   localparam logic [4:0]  OFF_TIMING  = 5'h00;
   localparam logic [4:0]  OFF_CONFIG  = 5'h04;
   localparam logic [4:0]  OFF_PROT    = 5'h08;
   localparam logic [4:0]  OFF_STATUS  = 5'h0C;
   localparam logic [4:0]  OFF_COMMAND = 5'h10;
   // ****************************************
   // Field positions
   // ****************************************
   localparam int STAT_BEF    = 7;
   localparam int STAT_CCF    = 6;
   localparam int STAT_PROTECTION_VIOLATION_FLAG  = 5;
   localparam int STAT_ACCESS_ERROR_FLAG = 4;
   localparam int STAT_BLANK  = 2;
   localparam int CFG_BEIE    = 7;
   localparam int CFG_COMPLETE_IRQ_ENABLE    = 6;
   localparam int PROT_EN     = 8;
   localparam int DIV_PRE8    = 6;
   // ****************************************
   // Reset values and constants
   // ****************************************
   localparam logic [6:0]  DIV_RST     = 7'h00;
   localparam logic [8:0]  PROT_RST    = 9'h000;
   localparam logic [31:0] ERASED_WORD = 32'hFFFF_FFFF;
   localparam logic [15:0] ERASED_HALF = 16'hFFFF;
   localparam logic [3:0]  SEL_LOW     = 4'h3;
   localparam logic [3:0]  SEL_HIGH    = 4'hC;
   localparam logic [8:0]  LAST_SECTOR = 9'h1FF;
   localparam logic [7:0]  OP_TICKS    = 8'h20;
   // ****************************************
   // Commands
   // ****************************************
   localparam logic [7:0] CMD_ERASE_VERIFY  = 8'h05;
   localparam logic [7:0] CMD_PROGRAM       = 8'h20;
   localparam logic [7:0] CMD_SECTOR_ERASE  = 8'h40;
   localparam logic [7:0] CMD_MASS_ERASE    = 8'h41;
   localparam logic [7:0] CMD_SECTOR_MODIFY = 8'h60;
   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [1:0] {SEQ_IDLE = 2'b00, SEQ_WORD = 2'b01, SEQ_CMD = 2'b10} ecec_seq_t;
   typedef enum logic [1:0] {EX_IDLE = 2'b00, EX_TIME = 2'b01, EX_SWEEP = 2'b10} ecec_ex_t;
   typedef struct packed {
      logic [7:0]  cmd;
      logic [8:0]  sector;
      logic        hi;
      logic [15:0] data;
   } ecec_slot_t;
endpackage
`default_nettype wire

/* File: src/ecec_top.sv */
`timescale 1ns/1ps
`default_nettype none
module ecec_top (
   input  wire logic        REF_CLK,
   input  wire logic        RST,
   input  wire logic        WB_CYC_I,
   input  wire logic        WB_STB_I,
   input  wire logic        WB_WE_I,
   input  wire logic [31:0] WB_ADR_I,
   input  wire logic [3:0]  WB_SEL_I,
   input  wire logic [31:0] WB_DAT_I,
   output var  logic [31:0] WB_DAT_O,
   output var  logic        WB_ACK_O,
   input  wire logic        STOP_MODE,
   input  wire logic        WAIT_MODE,
   input  wire logic        BDM_ACTIVE,
   input  wire logic        CHIP_SECURED,
   input  wire logic        SPECIAL_MODE,
   input  wire logic        GLOBAL_IRQ_MASK,
   output logic             IRQ_BUFFER_EMPTY,
   output logic             IRQ_COMPLETE,
   output logic             WAKE_REQ,
   output logic             HV_ENABLE
);
   // ****************************************
   // State
   // ****************************************
   ecec_pkg::ecec_seq_t  seq;
   ecec_pkg::ecec_seq_t  next_seq;
   ecec_pkg::ecec_ex_t   ex;
   ecec_pkg::ecec_slot_t buf_slot;
   ecec_pkg::ecec_slot_t pend;
   ecec_pkg::ecec_slot_t act;
   logic        pend_valid;
   logic        act_valid;
   logic        bef;
   logic        ccf;
   logic        access_error_flag;
   logic        protection_violation_flag;
   logic        blank;
   logic        blank_acc;
   logic        div_loaded;
   logic        prot_written;
   logic        stop_q;
   logic        beie;
   logic        complete_irq_enable;
   logic [6:0]  div;
   logic [8:0]  prot;
   logic [8:0]  pre;
   logic [7:0]  ticks;
   logic [8:0]  ptr;
   logic [31:0] mem [0:511];

   function automatic logic reg_hit(input logic [31:0] a, input logic [4:0] off);
      reg_hit = ((a & ecec_pkg::REGS_MASK) == 32'h0000_0000) && (a[4:2] == off[4:2]);
   endfunction

   function automatic logic cmd_valid(input logic [7:0] c);
      cmd_valid = (c == ecec_pkg::CMD_ERASE_VERIFY) || (c == ecec_pkg::CMD_PROGRAM) ||
                  (c == ecec_pkg::CMD_SECTOR_ERASE) || (c == ecec_pkg::CMD_MASS_ERASE) ||
                  (c == ecec_pkg::CMD_SECTOR_MODIFY);
   endfunction

   // ****************************************
   // Bus decode
   // ****************************************
   wire req        = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
   wire wr         = req & WB_WE_I;
   wire in_array   = (WB_ADR_I & ecec_pkg::ARRAY_MASK) == ecec_pkg::ARRAY_BASE;
   wire in_regs    = (WB_ADR_I & ecec_pkg::REGS_MASK) == 32'h0000_0000;
   wire wr_array   = wr & in_array;
   wire wr_reg     = wr & in_regs;
   wire wr_timing  = wr & reg_hit(WB_ADR_I, ecec_pkg::OFF_TIMING);
   wire wr_config  = wr & reg_hit(WB_ADR_I, ecec_pkg::OFF_CONFIG);
   wire wr_prot    = wr & reg_hit(WB_ADR_I, ecec_pkg::OFF_PROT);
   wire wr_status  = wr & reg_hit(WB_ADR_I, ecec_pkg::OFF_STATUS);
   wire wr_command = wr & reg_hit(WB_ADR_I, ecec_pkg::OFF_COMMAND);
   wire sel_hi     = WB_SEL_I == ecec_pkg::SEL_HIGH;
   wire word_sel   = sel_hi | (WB_SEL_I == ecec_pkg::SEL_LOW);
   wire [7:0] code = WB_DAT_I[7:0];
   wire in_word    = seq == ecec_pkg::SEQ_WORD;
   wire in_cmd     = seq == ecec_pkg::SEQ_CMD;
   wire locked     = access_error_flag | protection_violation_flag;
   wire stop_rise  = STOP_MODE & ~stop_q;
   wire stop_fall  = ~STOP_MODE & stop_q;

   // ****************************************
   // Sequence errors
   // ****************************************
   // divider not loaded
   wire err_nodiv  = wr_array & ~div_loaded;
   wire err_align  = wr_array & ~word_sel;
   wire err_full   = wr_array & ~bef;
   wire err_word2  = wr_array & (seq != ecec_pkg::SEQ_IDLE);
   wire err_fw1    = wr_reg & in_word & ~wr_command;
   wire err_cmd2   = wr_command & in_cmd;
   wire err_fw2    = wr_reg & in_cmd & ~wr_status;
   wire err_code   = wr_command & in_word & ~SPECIAL_MODE & ~cmd_valid(code);
   // secured special mode runs only mass erase
   wire err_secure = wr_command & in_word & CHIP_SECURED & SPECIAL_MODE &
                     (code != ecec_pkg::CMD_MASS_ERASE);
   wire err_zero   = wr_status & (seq != ecec_pkg::SEQ_IDLE) & ~WB_DAT_I[ecec_pkg::STAT_BEF];
   // stop with a command in flight
   wire stop_abort = stop_rise & ~ccf;
   wire acc_set    = err_nodiv | err_align | err_full | err_word2 | err_fw1 | err_cmd2 |
                     err_fw2 | err_code | err_secure | err_zero | stop_abort;

   wire prot_hit   = prot[ecec_pkg::PROT_EN] & (buf_slot.sector[8:1] >= prot[7:0]);
   wire prog_like  = (code == ecec_pkg::CMD_PROGRAM) | (code == ecec_pkg::CMD_SECTOR_MODIFY);
   wire erase_like = (code == ecec_pkg::CMD_SECTOR_ERASE) | (code == ecec_pkg::CMD_SECTOR_MODIFY);
   wire cmd_try    = wr_command & in_word & ~err_code & ~err_secure;
   wire pv_set     = cmd_try & (((prog_like | erase_like) & prot_hit) |
                     ((code == ecec_pkg::CMD_MASS_ERASE) & prot[ecec_pkg::PROT_EN]));

   wire accept_word = wr_array & ~err_nodiv & ~err_align & ~err_full & ~err_word2;
   wire accept_cmd  = cmd_try & ~pv_set;
   wire launch      = wr_status & in_cmd & WB_DAT_I[ecec_pkg::STAT_BEF] & ~locked & bef;
   wire promote     = pend_valid & ~act_valid & ~STOP_MODE;

   always_comb begin
      next_seq = seq;
      if (acc_set | pv_set) begin
         next_seq = ecec_pkg::SEQ_IDLE;
      end else if (accept_word) begin
         next_seq = ecec_pkg::SEQ_WORD;
      end else if (accept_cmd) begin
         next_seq = ecec_pkg::SEQ_CMD;
      end else if (launch) begin
         next_seq = ecec_pkg::SEQ_IDLE;
      end
   end

   // ****************************************
   // Execution timing
   // ****************************************
   // Prescale by eight stretches the tick for fast reference clocks
   wire [8:0] pre_limit = div[ecec_pkg::DIV_PRE8] ? {div[5:0], 3'b111} : {3'b000, div[5:0]};
   wire pre_wrap   = pre == pre_limit;
   // wait mode does not gate the engine
   wire tick_last  = (ex == ecec_pkg::EX_TIME) & pre_wrap & ~STOP_MODE &
                     (ticks == ecec_pkg::OP_TICKS - 8'h01);
   wire sweep_cmd  = (act.cmd == ecec_pkg::CMD_MASS_ERASE) |
                     (act.cmd == ecec_pkg::CMD_ERASE_VERIFY);
   wire apply      = tick_last & ~sweep_cmd;
   wire sweep_on   = (ex == ecec_pkg::EX_SWEEP) & ~STOP_MODE;
   wire sweep_last = sweep_on & (ptr == ecec_pkg::LAST_SECTOR);
   wire done       = apply | sweep_last;
   wire erased_now = mem[ptr] == ecec_pkg::ERASED_WORD;

   // ****************************************
   // Control registers
   // ****************************************
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         div          <= ecec_pkg::DIV_RST;
         div_loaded   <= 1'b0;
         prot         <= ecec_pkg::PROT_RST;
         prot_written <= 1'b0;
         beie         <= 1'b0;
         complete_irq_enable         <= 1'b0;
         stop_q       <= 1'b0;
      end else begin
         stop_q <= STOP_MODE;
         if (wr_timing) begin
            div        <= WB_DAT_I[6:0];
            div_loaded <= 1'b1;
         end
         if (wr_config) begin
            beie <= WB_DAT_I[ecec_pkg::CFG_BEIE];
            complete_irq_enable <= WB_DAT_I[ecec_pkg::CFG_COMPLETE_IRQ_ENABLE];
         end
         if (wr_prot & (BDM_ACTIVE | ~prot_written)) begin
            prot         <= WB_DAT_I[8:0];
            prot_written <= 1'b1;
         end
      end
   end

   // ****************************************
   // Flags and sequence
   // ****************************************
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         seq    <= ecec_pkg::SEQ_IDLE;
         access_error_flag <= 1'b0;
         protection_violation_flag  <= 1'b0;
         bef    <= 1'b1;
         ccf    <= 1'b1;
         blank  <= 1'b0;
      end else begin
         seq <= next_seq;
         // write one clears, a new set wins
         access_error_flag <= acc_set | (access_error_flag & ~(wr_status & WB_DAT_I[ecec_pkg::STAT_ACCESS_ERROR_FLAG]));
         protection_violation_flag  <= pv_set | (protection_violation_flag & ~(wr_status & WB_DAT_I[ecec_pkg::STAT_PROTECTION_VIOLATION_FLAG]));
         if (promote | stop_fall) begin
            bef <= 1'b1;
         end else if (launch) begin
            bef <= 1'b0;
         end
         if (stop_abort | (done & ~pend_valid & ~launch)) begin
            ccf <= 1'b1;
         end else if (launch) begin
            ccf <= 1'b0;
         end
         if (sweep_last & (act.cmd == ecec_pkg::CMD_ERASE_VERIFY)) begin
            blank <= blank_acc & erased_now;
         end else if (launch) begin
            blank <= 1'b0;
         end
      end
   end

   // ****************************************
   // Command buffers
   // ****************************************
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         buf_slot   <= '0;
         pend       <= '0;
         pend_valid <= 1'b0;
      end else begin
         if (accept_word) begin
            buf_slot.sector <= WB_ADR_I[10:2];
            buf_slot.hi     <= sel_hi;
            buf_slot.data   <= sel_hi ? WB_DAT_I[31:16] : WB_DAT_I[15:0];
         end
         if (accept_cmd) begin
            buf_slot.cmd <= code;
         end
         if (stop_rise) begin
            pend_valid <= 1'b0;
         end else if (launch) begin
            pend       <= buf_slot;
            pend_valid <= 1'b1;
         end else if (promote) begin
            pend_valid <= 1'b0;
         end
      end
   end

   // ****************************************
   // Execution engine
   // ****************************************
   // asynchronous reset drops the active command
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         ex        <= ecec_pkg::EX_IDLE;
         act       <= '0;
         act_valid <= 1'b0;
         pre       <= 9'h000;
         ticks     <= 8'h00;
         ptr       <= 9'h000;
         blank_acc <= 1'b0;
      end else if (stop_rise) begin
         ex        <= ecec_pkg::EX_IDLE;
         act_valid <= 1'b0;
      end else if (promote) begin
         act       <= pend;
         act_valid <= 1'b1;
         ex        <= ecec_pkg::EX_TIME;
         pre       <= 9'h000;
         ticks     <= 8'h00;
      end else if (done) begin
         ex        <= ecec_pkg::EX_IDLE;
         act_valid <= 1'b0;
      end else if ((ex == ecec_pkg::EX_TIME) & ~STOP_MODE) begin
         pre <= pre_wrap ? 9'h000 : pre + 9'h001;
         if (pre_wrap) begin
            ticks <= ticks + 8'h01;
         end
         if (tick_last) begin
            ex        <= ecec_pkg::EX_SWEEP;
            ptr       <= 9'h000;
            blank_acc <= 1'b1;
         end
      end else if (sweep_on) begin
         ptr       <= ptr + 9'h001;
         blank_acc <= blank_acc & erased_now;
      end
   end

   // Array cells have no reset; an aborted operation leaves the cells it has not yet written unchanged
   always_ff @(posedge REF_CLK) begin
      if (apply) begin
         case (act.cmd)
            ecec_pkg::CMD_PROGRAM: begin
               mem[act.sector] <= act.hi ? {act.data, mem[act.sector][15:0]}
                                         : {mem[act.sector][31:16], act.data};
            end
            ecec_pkg::CMD_SECTOR_ERASE: begin
               mem[act.sector] <= ecec_pkg::ERASED_WORD;
            end
            ecec_pkg::CMD_SECTOR_MODIFY: begin
               mem[act.sector] <= act.hi ? {act.data, ecec_pkg::ERASED_HALF}
                                         : {ecec_pkg::ERASED_HALF, act.data};
            end
            default: begin
            end
         endcase
      end
      if (sweep_on & (act.cmd == ecec_pkg::CMD_MASS_ERASE)) begin
         mem[ptr] <= ecec_pkg::ERASED_WORD;
      end
   end

   // ****************************************
   // Read path and bus answer
   // ****************************************
   wire [31:0] reg_rdata =
      reg_hit(WB_ADR_I, ecec_pkg::OFF_TIMING)  ? {25'h0000000, div} :
      reg_hit(WB_ADR_I, ecec_pkg::OFF_CONFIG)  ? {24'h000000, beie, complete_irq_enable, 6'h00} :
      reg_hit(WB_ADR_I, ecec_pkg::OFF_PROT)    ? {23'h000000, prot} :
      reg_hit(WB_ADR_I, ecec_pkg::OFF_STATUS)  ?
         {24'h000000, bef, ccf, protection_violation_flag, access_error_flag, 1'b0, blank, 2'b00} :
      reg_hit(WB_ADR_I, ecec_pkg::OFF_COMMAND) ? {24'h000000, buf_slot.cmd} : 32'h0000_0000;
   // array reads are never checked against busy
   wire [31:0] rd_data = in_array ? mem[WB_ADR_I[10:2]] : in_regs ? reg_rdata : 32'h0000_0000;

   // reads only load the data register
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         WB_ACK_O <= 1'b0;
         WB_DAT_O <= 32'h0000_0000;
      end else begin
         WB_ACK_O <= req;
         if (req & ~WB_WE_I) begin
            WB_DAT_O <= rd_data;
         end
      end
   end

   // ****************************************
   // Interrupts and supply
   // ****************************************
   // buffer-empty request
   assign IRQ_BUFFER_EMPTY = bef & beie & ~GLOBAL_IRQ_MASK;
   assign IRQ_COMPLETE     = ccf & complete_irq_enable & ~GLOBAL_IRQ_MASK;
   assign WAKE_REQ         = WAIT_MODE & (IRQ_BUFFER_EMPTY | IRQ_COMPLETE);
   assign HV_ENABLE        = act_valid & ~STOP_MODE;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (RST);

   sequence s_launch_idle;
      launch && !act_valid && !STOP_MODE;
   endsequence
   sequence s_refill;
      !ccf && !bef ##1 !STOP_MODE ##1 bef;
   endsequence

   nodiv_error_a: assert property (err_nodiv |=> access_error_flag && seq == ecec_pkg::SEQ_IDLE)
      else $error("array write before divider load did not flag");
   align_error_a: assert property (wr_array && !word_sel |=> access_error_flag)
      else $error("misaligned array write did not flag");
   full_error_a: assert property (wr_array && !bef |=> access_error_flag && !pend_valid || access_error_flag)
      else $error("array write with full buffers did not flag");
   second_word_a: assert property (wr_array && in_word |=> access_error_flag && seq == ecec_pkg::SEQ_IDLE)
      else $error("second word did not abort");
   foreign_write_a: assert property (wr_timing && in_cmd |=> access_error_flag && seq == ecec_pkg::SEQ_IDLE && bef)
      else $error("foreign write after command did not abort");
   bad_code_a: assert property (wr_command && in_word && !SPECIAL_MODE && !cmd_valid(code)
      |=> access_error_flag && seq == ecec_pkg::SEQ_IDLE)
      else $error("invalid command accepted");
   stop_abort_a: assert property (stop_rise && !ccf |=> ccf && access_error_flag && !HV_ENABLE && !pend_valid)
      else $error("stop entry did not abort command");
   zero_bef_a: assert property (wr_status && in_cmd && !WB_DAT_I[ecec_pkg::STAT_BEF]
      |=> access_error_flag && seq == ecec_pkg::SEQ_IDLE && bef)
      else $error("zero to buffer-empty did not abort");
   read_quiet_a: assert property (req && !WB_WE_I && !stop_rise
      |=> seq == $past(seq) && access_error_flag == $past(access_error_flag))
      else $error("register read disturbed the sequence");
   lock_hold_a: assert property (wr_status && in_cmd && locked && WB_DAT_I[ecec_pkg::STAT_BEF] &&
      !WB_DAT_I[ecec_pkg::STAT_ACCESS_ERROR_FLAG] && !WB_DAT_I[ecec_pkg::STAT_PROTECTION_VIOLATION_FLAG]
      |=> seq == ecec_pkg::SEQ_CMD && bef)
      else $error("launch taken while locked");
   protect_hit_a: assert property (pv_set |=> protection_violation_flag && seq == ecec_pkg::SEQ_IDLE)
      else $error("protected access did not flag");
   launch_refill_a: assert property (s_launch_idle |=> s_refill)
      else $error("launch did not clear and refill");
   complete_last_a: assert property (done && !pend_valid && !launch |=> ccf && !act_valid)
      else $error("completion flag missing after last command");
   stop_exit_a: assert property ($fell(STOP_MODE) |=> bef && !act_valid)
      else $error("stop exit did not restore buffer-empty");
   irq_done_a: assert property ($rose(ccf) && complete_irq_enable && !GLOBAL_IRQ_MASK |-> IRQ_COMPLETE)
      else $error("completion interrupt missing");
endmodule
`default_nettype wire

/* File: tb/ecec_host.sv */
`timescale 1ns/1ps
`default_nettype none
// ************
// Host bus master
// ************
module ecec_host (
   input  wire logic        clk,
   input  wire logic        ack,
   input  wire logic [31:0] rdat,
   output var  logic        cyc,
   output var  logic        we,
   output var  logic [31:0] adr,
   output var  logic [3:0]  sel,
   output var  logic [31:0] wdat
);
   initial begin
      cyc = 1'b0;
      we = 1'b0;
      adr = 32'h0;
      sel = 4'h0;
      wdat = 32'h0;
   end
   // one read or write bus transfer
   // Request held until the edge that sees ack, so no early release
   task automatic xfer(input logic w, input logic [31:0] a, input logic [3:0] s,
                       input logic [31:0] d, output logic [31:0] r);
      @(posedge clk);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      sel <= s;
      wdat <= d;
      do @(posedge clk); while (ack !== 1'b1);
      r = rdat;
      cyc <= 1'b0;
   endtask
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
// ************
// Bench
// ************
module testbench;
   logic        ref_clk, rst, stop_m, wait_m, background_debug_mode, mask, sec, spc;
   logic        cyc, we, ack, irq_be, irq_cc, wake, hv;
   logic [31:0] adr, wdat, rdat, q;
   logic [3:0]  sel;
   int          mismatches, total_checks, cycles;
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   ecec_host i_host (.clk(ref_clk), .ack(ack), .rdat(rdat), .cyc(cyc), .we(we),
      .adr(adr), .sel(sel), .wdat(wdat));
   ecec_top i_dut (.REF_CLK(ref_clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(cyc),
      .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
      .WB_ACK_O(ack), .STOP_MODE(stop_m), .WAIT_MODE(wait_m), .BDM_ACTIVE(background_debug_mode),
      .CHIP_SECURED(sec), .SPECIAL_MODE(spc), .GLOBAL_IRQ_MASK(mask),
      .IRQ_BUFFER_EMPTY(irq_be), .IRQ_COMPLETE(irq_cc), .WAKE_REQ(wake), .HV_ENABLE(hv));
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      i_host.xfer(1'b1, a, 4'hF, d, q);
   endtask
   task automatic wa(input logic [3:0] s);
      i_host.xfer(1'b1, 32'h800, s, 32'h1234, q);
   endtask
   task automatic st(input logic [31:0] e);
      i_host.xfer(1'b0, 32'hC, 4'hF, 32'h0, q);
      chk(q & 32'hF0, e);
   endtask
   task automatic run(input logic [7:0] c);
      wa(4'h3);
      wr(32'h10, {24'h0, c});
      wr(32'hC, 32'h80);
   endtask
   task automatic poll();
      q = 32'h0;
      for (int i = 0; i < 400 && q[6] !== 1'b1; i++) i_host.xfer(1'b0, 32'hC, 4'hF, 32'h0, q);
      chk(q & 32'hF0, 32'hC0);
   endtask
   task automatic seq_err(input logic [31:0] a, input logic [3:0] s, input logic [31:0] d);
      wa(4'h3);
      i_host.xfer(1'b1, a, s, d, q);
      st(32'hD0);
      wr(32'hC, 32'h30);
   endtask
   task automatic cmd_err(input logic [31:0] a, input logic [31:0] d);
      wa(4'h3);
      wr(32'h10, 32'h20);
      wr(a, d);
      st(32'hD0);
      wr(32'hC, 32'h30);
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      i_host.xfer(1'b0, a, 4'hF, 32'h0, q);
      chk(q, e);
   endtask
   task automatic t_seq();
      st(32'hC0);
      wa(4'h3);
      st(32'hD0);
      wr(32'hC, 32'h30);
      wr(32'h0, 32'h0);
      wa(4'hF);
      st(32'hD0);
      wr(32'hC, 32'h30);
      seq_err(32'h804, 4'h3, 32'h0);
      seq_err(32'h4, 4'hF, 32'h0);
      seq_err(32'hC, 4'hF, 32'h0);
      seq_err(32'h10, 4'hF, 32'h33);
      cmd_err(32'h10, 32'h20);
      cmd_err(32'h0, 32'h0);
      wa(4'h3);
      st(32'hC0);
      wr(32'h10, 32'h20);
      wr(32'hC, 32'h80);
      @(posedge ref_clk) wait_m <= 1'b1;
      i_host.xfer(1'b0, 32'h800, 4'hF, 32'h0, q);
      st(32'h80);
      poll();
      run(8'h60);
      poll();
      run(8'h41);
      poll();
      run(8'h05);
      poll();
      rd(32'hC, 32'hC4);
      $display("t_seq done");
   endtask
   task automatic t_irq();
      wr(32'h4, 32'hC0);
      chk({31'h0, irq_be}, 32'h1);
      chk({31'h0, irq_cc}, 32'h1);
      chk({31'h0, wake}, 32'h1);
      @(posedge ref_clk) mask <= 1'b1;
      @(posedge ref_clk);
      chk({30'h0, irq_be, irq_cc}, 32'h0);
      wr(32'h4, 32'h0);
      $display("t_irq done");
   endtask
   task automatic t_prot();
      wr(32'h8, 32'h100);
      run(8'h41);
      st(32'hE0);
      wr(32'hC, 32'h30);
      run(8'h20);
      st(32'hE0);
      wr(32'hC, 32'h30);
      run(8'h40);
      st(32'hE0);
      wr(32'h8, 32'h0);
      rd(32'h8, 32'h100);
      @(posedge ref_clk) background_debug_mode <= 1'b1;
      wr(32'h8, 32'h0);
      rd(32'h8, 32'h0);
      run(8'h40);
      st(32'hE0);
      wr(32'hC, 32'h30);
      wr(32'hC, 32'h30);
      st(32'hC0);
      run(8'h41);
      run(8'h20);
      wa(4'h3);
      st(32'h10);
      repeat (4) @(posedge ref_clk);
      chk({31'h0, hv}, 32'h1);
      @(posedge ref_clk) stop_m <= 1'b1;
      repeat (2) @(posedge ref_clk);
      chk({31'h0, hv}, 32'h0);
      st(32'h50);
      @(posedge ref_clk) stop_m <= 1'b0;
      st(32'hD0);
      chk({31'h0, hv}, 32'h0);
      wr(32'hC, 32'h30);
      @(posedge ref_clk) {sec, spc} <= 2'b11;
      run(8'h20);
      st(32'hD0);
      wr(32'hC, 32'h30);
      @(posedge ref_clk) {sec, spc} <= 2'b00;
      $display("t_prot done");
   endtask
   task automatic t_rst();
      run(8'h20);
      @(posedge ref_clk);
      chk({31'h0, hv}, 32'h1);
      @(posedge ref_clk) rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      st(32'hC0);
      chk({31'h0, hv}, 32'h0);
      $display("t_rst done");
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         print_verdict();
      end
   end
   initial begin
      {rst, stop_m, wait_m, background_debug_mode, mask} = 5'h10;
      {sec, spc} = 2'b00;
      repeat (20) @(posedge ref_clk);
      rst <= 1'b0;
      t_seq();
      t_irq();
      t_prot();
      t_rst();
      print_verdict();
   end
endmodule
`default_nettype wire
